// *** rtl/mode_reg_pkg.sv ***
// Constants, field positions and decode functions for the mode register block
package mode_reg_pkg;

  // Command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;

  // Bank address codes selecting a mode register
  localparam logic [2:0] BA_MODE_ZERO = 3'h0;
  localparam logic [2:0] BA_MODE_ONE = 3'h1;
  localparam logic [2:0] BA_MODE_TWO = 3'h2;

  // Field positions
  localparam int BURST_TYPE_BIT = 3;
  localparam int TEST_MODE_BIT = 7;
  localparam int LOOP_RESET_BIT = 8;
  localparam int PPD_LOOP_BIT = 12;
  localparam int LOOP_DISABLE_BIT = 0;
  localparam int BURST_CHOP_BIT = 12;
  localparam int DRIVE_LO_BIT = 1;
  localparam int DRIVE_HI_BIT = 5;

  // Burst length field codes
  localparam logic [1:0] BL_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BL_FIXED_FOUR = 2'h2;

  // Commit offsets after first write beat, minus one
  localparam logic [1:0] COMMIT_EIGHT = 2'h3;
  localparam logic [1:0] COMMIT_FOUR = 2'h1;

  // Loop lock time in clocks
  localparam int LOOP_LOCK_CK = 512;

  // Software register offsets
  localparam logic [2:0] REG_MODE_ZERO = 3'h0;
  localparam logic [2:0] REG_MODE_ONE = 3'h1;
  localparam logic [2:0] REG_MODE_TWO = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_LOCK_LIMIT = 3'h4;

  // Reset values
  localparam logic [12:0] MODE_RESET = 13'h0000;

  function automatic logic [5:0] read_latency_setting(input logic [12:0] mr);
    read_latency_setting = {3'h0, mr[6:4]} + 6'h04 + (mr[2] ? 6'h08 : 6'h00);
  endfunction : read_latency_setting

  function automatic logic [5:0] write_latency_setting(input logic [12:0] mr);
    write_latency_setting = {3'h0, mr[5:3]} + 6'h05;
  endfunction : write_latency_setting

  function automatic logic [5:0] added_latency(input logic [12:0] mr,
    input logic [5:0] rd_setting);
    unique case ({mr[4], mr[3]})
      2'h1: added_latency = rd_setting - 6'h01;
      2'h2: added_latency = rd_setting - 6'h02;
      default: added_latency = 6'h00;
    endcase
  endfunction : added_latency

endpackage : mode_reg_pkg

// *** rtl/burst_column_order.sv ***
// Column index of one beat within a read or write burst
`timescale 1ns/1ps
`default_nettype none
module burst_column_order (
  // Burst description
  input wire logic [2:0] start,
  input wire logic [2:0] beat,
  input wire logic interleave,
  input wire logic chop,
  input wire logic is_write,
  // Result
  output logic [2:0] col
);

  always_comb begin
    if (is_write) begin
      col = chop ? {start[2], beat[1:0]} : beat;
    end else if (interleave) begin
      col = start ^ beat;
    end else begin
      col = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
    end
  end

endmodule : burst_column_order
`default_nettype wire

// *** rtl/ddr3_mode_register_decode.sv ***
// Mode register decode, burst ordering and latency timing of the memory device
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Burst type clear: sequential order, low bits count and wrap in four.
// - Burst type set: beat column is start column XOR beat number.
// - Chopped read stays in start group; drivers off for last four beats.
// - Writes: chop uses only start bit two, full burst always 0 to 7.
// - Fixed chop: internal write commit two clocks earlier than eight.
// - Per-command chop: commit at same time as a burst of eight.
// - Read latency setting from register-zero bits two, four, five, six.
// - Total read latency is added latency plus read latency setting.
// - Register-zero bit seven selects unspecified test mode; keep zero.
// - Loop reset bit returns to zero once the reset is performed.
// - Register-zero bits nine to eleven hold write recovery clocks.
// - Bit twelve zero freezes loop in power-down; one keeps it running.
// - Command with bank bits 001 writes mode register one.
// - Loop stops on self-refresh entry and restarts on exit.
// - Driver impedance from register-one bits one and five.
// - Register-one bits four, three give added latency and delay commands.
// - Total write latency is added latency plus write latency setting.
// - Burst length from register-zero bits zero and one.
// - Command with bank bits 000 writes mode register zero.
// - Register-one bit zero set disables the loop until cleared.
module ddr3_mode_register_decode
  import mode_reg_pkg::*;
#(
  parameter int LOCK_CYCLES = LOOP_LOCK_CK
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Command and address pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  // Software register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Read burst
  output logic [2:0] rd_col,
  output logic rd_beat_valid,
  output logic dq_oe,
  output logic dqs_oe,
  output logic int_read,
  // Write burst
  output logic [2:0] wr_col,
  output logic wr_beat_valid,
  output logic int_write,
  output logic write_commit,
  // Mode and loop state
  output logic dll_running,
  output logic dll_locked,
  output logic dll_reset_busy,
  output logic [1:0] drive_impedance,
  output logic test_mode,
  output logic [3:0] write_recovery_code,
  output logic [5:0] total_read_latency,
  output logic [5:0] total_write_latency
);

  typedef struct packed {
    logic [12:0] mode_reg_zero;
    logic [12:0] mode_reg_one;
    logic [12:0] mode_reg_two;
    logic cke_prev;
    logic self_ref;
    logic pdown;
    logic [5:0] total_read_latency;
    logic [5:0] total_write_latency;
    logic rd_pend;
    logic [5:0] rd_cnt;
    logic [5:0] rd_total;
    logic [5:0] rd_setting;
    logic [2:0] rd_start;
    logic rd_il;
    logic rd_chop;
    logic rd_active;
    logic [2:0] rd_next;
    logic [2:0] rd_idx;
    logic [2:0] rd_col;
    logic rd_valid;
    logic dq_oe;
    logic int_read;
    logic wr_pend;
    logic [5:0] wr_cnt;
    logic [5:0] wr_setting;
    logic [2:0] wr_start;
    logic wr_chop;
    logic wr_fix4;
    logic wr_active;
    logic [2:0] wr_next;
    logic [2:0] wr_idx;
    logic [2:0] wr_col;
    logic wr_valid;
    logic int_write;
    logic commit_run;
    logic [1:0] commit_cnt;
    logic commit;
    logic dll_rst;
    logic [15:0] lock_cnt;
    logic locked;
    logic dll_run;
    logic [15:0] lock_limit;
    logic [31:0] rdata;
  } state_t;

  logic [1:0] rst_sync_q;
  logic rst_n;
  state_t q, d;
  logic [3:0] cmd;
  logic cmd_ok;
  logic rd_take;
  logic wr_take;
  logic rd_show;
  logic wr_show;
  logic [5:0] read_latency_setting_c;
  logic [5:0] added_latency_c;
  logic [5:0] write_latency_setting_c;
  logic [2:0] rd_col_c;
  logic [2:0] wr_col_c;

  // Reset released through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // Commands only while clock enable stays high
  assign cmd_ok = cke && q.cke_prev;
  assign rd_take = cmd_ok && cmd == CMD_READ && !q.rd_pend && !q.rd_active;
  assign wr_take = cmd_ok && cmd == CMD_WRITE && !q.wr_pend && !q.wr_active;
  assign rd_show = (q.rd_pend && q.rd_cnt == 6'h00) || (q.rd_active && q.rd_idx != 3'h7);
  assign wr_show = (q.wr_pend && q.wr_cnt == 6'h00) || (q.wr_active && q.wr_idx != 3'h7);

  assign read_latency_setting_c = read_latency_setting(q.mode_reg_zero);
  assign added_latency_c = added_latency(q.mode_reg_one, read_latency_setting_c);
  assign write_latency_setting_c = write_latency_setting(q.mode_reg_two);

  burst_column_order u_rd_order (
    .start(q.rd_start),
    .beat(q.rd_next),
    .interleave(q.rd_il),
    .chop(q.rd_chop),
    .is_write(1'b0),
    .col(rd_col_c)
  );

  burst_column_order u_wr_order (
    .start(q.wr_start),
    .beat(q.wr_next),
    .interleave(1'b0),
    .chop(q.wr_chop),
    .is_write(1'b1),
    .col(wr_col_c)
  );

  always_comb begin
    d = q;
    d.int_read = 1'b0;
    d.int_write = 1'b0;
    d.commit = 1'b0;
    d.rdata = 32'h0000_0000;
    d.cke_prev = cke;
    d.total_read_latency = added_latency_c + read_latency_setting_c;
    d.total_write_latency = added_latency_c + write_latency_setting_c;

    if (q.dll_rst) begin
      d.dll_rst = 1'b0;
      d.mode_reg_zero[LOOP_RESET_BIT] = 1'b0;
    end else if (q.dll_run && !q.locked) begin
      if (q.lock_cnt == 16'h0000) begin
        d.locked = 1'b1;
      end else begin
        d.lock_cnt = q.lock_cnt - 16'h0001;
      end
    end

    // registers load only on decoded command
    if (cmd_ok && cmd == CMD_MRS) begin
      unique case (ba)
        BA_MODE_ZERO: begin
          d.mode_reg_zero = addr[12:0];
          if (addr[LOOP_RESET_BIT]) begin
            d.dll_rst = 1'b1;
            d.lock_cnt = q.lock_limit;
            d.locked = 1'b0;
          end
        end
        BA_MODE_ONE: d.mode_reg_one = addr[12:0];
        BA_MODE_TWO: d.mode_reg_two = addr[12:0];
        default: ;
      endcase
    end

    if (q.mode_reg_one[LOOP_DISABLE_BIT]) begin
      d.locked = 1'b0;
    end
    // loop stopped in self-refresh or slow-exit power-down
    d.dll_run = !q.mode_reg_one[LOOP_DISABLE_BIT] && !q.self_ref
                && !(q.pdown && !q.mode_reg_zero[PPD_LOOP_BIT]);

    // Power states follow clock enable
    if (cke) begin
      d.self_ref = 1'b0;
      d.pdown = 1'b0;
    end else if (q.cke_prev) begin
      if (!cs_n && cmd == CMD_REFRESH) begin
        d.self_ref = 1'b1;
      end else begin
        d.pdown = 1'b1;
      end
    end

    // read held for added latency before internal issue
    if (rd_take) begin
      d.rd_pend = 1'b1;
      d.rd_cnt = added_latency_c + read_latency_setting_c - 6'h02;
      d.rd_total = added_latency_c + read_latency_setting_c;
      d.rd_setting = read_latency_setting_c;
      d.rd_start = addr[2:0];
      d.rd_il = q.mode_reg_zero[BURST_TYPE_BIT];
      // chop from length field or chop pin
      d.rd_chop = q.mode_reg_zero[1:0] == BL_FIXED_FOUR
                  || (q.mode_reg_zero[1:0] == BL_ON_THE_FLY && !addr[BURST_CHOP_BIT]);
      d.int_read = added_latency_c == 6'h00;
    end else if (q.rd_pend) begin
      d.int_read = q.rd_cnt == q.rd_setting - 6'h01;
      if (q.rd_cnt == 6'h00) begin
        d.rd_pend = 1'b0;
      end else begin
        d.rd_cnt = q.rd_cnt - 6'h01;
      end
    end

    if (rd_show) begin
      d.rd_active = 1'b1;
      d.rd_idx = q.rd_next;
      d.rd_col = rd_col_c;
      d.rd_next = q.rd_next + 3'h1;
      d.rd_valid = !(q.rd_chop && q.rd_next[2]);
      d.dq_oe = !(q.rd_chop && q.rd_next[2]);
    end else begin
      d.rd_active = 1'b0;
      d.rd_valid = 1'b0;
      d.dq_oe = 1'b0;
      d.rd_next = 3'h0;
    end

    // write held for added latency as well
    if (wr_take) begin
      d.wr_pend = 1'b1;
      d.wr_cnt = added_latency_c + write_latency_setting_c - 6'h02;
      d.wr_setting = write_latency_setting_c;
      d.wr_start = addr[2:0];
      d.wr_fix4 = q.mode_reg_zero[1:0] == BL_FIXED_FOUR;
      d.wr_chop = q.mode_reg_zero[1:0] == BL_FIXED_FOUR
                  || (q.mode_reg_zero[1:0] == BL_ON_THE_FLY && !addr[BURST_CHOP_BIT]);
      d.int_write = added_latency_c == 6'h00;
    end else if (q.wr_pend) begin
      d.int_write = q.wr_cnt == q.wr_setting - 6'h01;
      if (q.wr_cnt == 6'h00) begin
        d.wr_pend = 1'b0;
      end else begin
        d.wr_cnt = q.wr_cnt - 6'h01;
      end
    end

    if (q.commit_run) begin
      if (q.commit_cnt == 2'h0) begin
        d.commit = 1'b1;
        d.commit_run = 1'b0;
      end else begin
        d.commit_cnt = q.commit_cnt - 2'h1;
      end
    end

    if (wr_show) begin
      d.wr_active = 1'b1;
      d.wr_idx = q.wr_next;
      d.wr_col = wr_col_c;
      d.wr_next = q.wr_next + 3'h1;
      d.wr_valid = !(q.wr_chop && q.wr_next[2]);
      if (!q.wr_active) begin
        d.commit_run = 1'b1;
        // fixed chop commits two clocks earlier
        d.commit_cnt = q.wr_fix4 ? COMMIT_FOUR : COMMIT_EIGHT;
      end
    end else begin
      d.wr_active = 1'b0;
      d.wr_valid = 1'b0;
      d.wr_next = 3'h0;
    end

    // Software port; unmapped offsets read zero
    if (reg_wr && reg_addr == REG_LOCK_LIMIT) begin
      d.lock_limit = reg_wdata[15:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        REG_MODE_ZERO: d.rdata = {19'h0, q.mode_reg_zero};
        REG_MODE_ONE: d.rdata = {19'h0, q.mode_reg_one};
        REG_MODE_TWO: d.rdata = {19'h0, q.mode_reg_two};
        REG_STATUS: d.rdata = {12'h000, q.wr_pend || q.wr_active, q.rd_pend || q.rd_active,
                               q.dll_rst, q.mode_reg_zero[TEST_MODE_BIT], q.pdown, q.self_ref,
                               q.dll_run, q.locked, q.total_write_latency,
                               q.total_read_latency};
        REG_LOCK_LIMIT: d.rdata = {16'h0000, q.lock_limit};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode_reg_zero <= MODE_RESET;
      q.mode_reg_one <= MODE_RESET;
      q.mode_reg_two <= MODE_RESET;
      q.lock_limit <= 16'(LOCK_CYCLES);
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign rd_col = q.rd_col;
  assign rd_beat_valid = q.rd_valid;
  assign dq_oe = q.dq_oe;
  assign dqs_oe = q.dq_oe;
  assign int_read = q.int_read;
  assign wr_col = q.wr_col;
  assign wr_beat_valid = q.wr_valid;
  assign int_write = q.int_write;
  assign write_commit = q.commit;
  assign dll_running = q.dll_run;
  assign dll_locked = q.locked;
  assign dll_reset_busy = q.dll_rst;
  assign drive_impedance = {q.mode_reg_one[DRIVE_HI_BIT], q.mode_reg_one[DRIVE_LO_BIT]};
  assign test_mode = q.mode_reg_zero[TEST_MODE_BIT];
  assign write_recovery_code = {1'b0, q.mode_reg_zero[11:9]};
  assign total_read_latency = q.total_read_latency;
  assign total_write_latency = q.total_write_latency;

  // Cycles since the last accepted read, checked against latency
  logic [5:0] rd_age_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_age_q <= 6'h00;
    end else if (rd_take) begin
      rd_age_q <= 6'h01;
    end else if (rd_age_q != 6'h3f) begin
      rd_age_q <= rd_age_q + 6'h01;
    end
  end

  property p_seq_order;
    @(posedge clk) disable iff (!rst_n)
    (q.rd_valid && !q.rd_il && q.rd_idx[1:0] != 2'h3) ##1 q.rd_valid
      |-> q.rd_col[1:0] == $past(q.rd_col[1:0]) + 2'h1;
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("sequential beat order broken");

  property p_il_order;
    @(posedge clk) disable iff (!rst_n)
    q.rd_valid && q.rd_il |-> q.rd_col == (q.rd_start ^ q.rd_idx);
  endproperty
  a_il_order: assert property (p_il_order)
    else $error("interleaved beat order broken");

  property p_chop_tail;
    @(posedge clk) disable iff (!rst_n)
    q.rd_valid && q.rd_chop && q.rd_idx == 3'h3 |=> !dq_oe [*4] ##1 !q.rd_active;
  endproperty
  a_chop_tail: assert property (p_chop_tail)
    else $error("chopped read drove tail beats");

  property p_wr_full;
    @(posedge clk) disable iff (!rst_n)
    q.wr_valid && !q.wr_chop |-> q.wr_col == q.wr_idx;
  endproperty
  a_wr_full: assert property (p_wr_full)
    else $error("full write not in order");

  property p_commit_four;
    @(posedge clk) disable iff (!rst_n)
    q.wr_valid && q.wr_idx == 3'h0 && q.wr_fix4 |-> ##2 write_commit;
  endproperty
  a_commit_four: assert property (p_commit_four)
    else $error("fixed chop commit not two clocks early");

  property p_commit_eight;
    @(posedge clk) disable iff (!rst_n)
    q.wr_valid && q.wr_idx == 3'h0 && !q.wr_fix4 |-> !write_commit [*4] ##1 write_commit;
  endproperty
  a_commit_eight: assert property (p_commit_eight)
    else $error("eight beat commit time wrong");

  property p_read_latency;
    @(posedge clk) disable iff (!rst_n)
    q.rd_valid && q.rd_idx == 3'h0 |-> rd_age_q == q.rd_total;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("first read beat not at total latency");

  property p_loop_clear;
    @(posedge clk) disable iff (!rst_n)
    $rose(dll_reset_busy) |=> !dll_reset_busy && !q.mode_reg_zero[LOOP_RESET_BIT] && !dll_locked;
  endproperty
  a_loop_clear: assert property (p_loop_clear)
    else $error("loop reset bit did not self-clear");

  property p_mode_one_load;
    @(posedge clk) disable iff (!rst_n)
    cmd_ok && cmd == CMD_MRS && ba == BA_MODE_ONE |=> q.mode_reg_one == $past(addr[12:0]);
  endproperty
  a_mode_one_load: assert property (p_mode_one_load)
    else $error("register one not loaded");

  property p_self_ref_loop;
    @(posedge clk) disable iff (!rst_n)
    q.self_ref |=> !dll_running;
  endproperty
  a_self_ref_loop: assert property (p_self_ref_loop)
    else $error("loop running in self-refresh");

endmodule : ddr3_mode_register_decode
`default_nettype wire

// *** tb/ctrl_model.sv ***
// Memory controller model driving command, bank and address pins
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
  import mode_reg_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command and address pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr
);
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = 3'h0;
    addr = 14'h0000;
  end

  // One command cycle, then a NOP with idle pins flipped so stale values never pass
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    ba <= ~b;
    addr <= ~a;
  endtask : issue

  task automatic mrs(input logic [2:0] b, input logic [13:0] a);
    logic [13:0] v;
    v = a;
    if (b == BA_MODE_ONE) v = v & 14'h1aff;
    // leveling with outputs on: termination code 001 to 011 only
    if (b == BA_MODE_ONE && v[7] && !v[12]) v = {v[13:10], 1'b0, v[8:3], v[2] | !v[6], v[1:0]};
    if (b == BA_MODE_ONE && v[0]) v = v & 14'h3dbb;
    issue(CMD_MRS, b, v);
  endtask : mrs

  // cke held at the given level between these calls
  task automatic cke_set(input logic lvl, input logic sref);
    @(posedge clk);
    cke <= lvl;
    {cs_n, ras_n, cas_n, we_n} <= sref ? CMD_REFRESH : 4'h7;
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
  endtask : cke_set
endmodule : ctrl_model
`default_nettype wire

// *** tb/ddr3_mode_register_decode_tb.sv ***
// Testbench for the mode register decode block
`timescale 1ns/1ps
`default_nettype none
module ddr3_mode_register_decode_tb
  import mode_reg_pkg::*;
;
  logic clk, reset_n, cke, cs_n, ras_n, cas_n, we_n, reg_wr, reg_rd;
  logic [2:0] ba, reg_addr, rd_col, wr_col;
  logic [13:0] addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic rd_beat_valid, dq_oe, dqs_oe, int_read, wr_beat_valid, int_write, write_commit;
  logic dll_running, dll_locked, dll_reset_busy, test_mode;
  logic [1:0] drive_impedance;
  logic [3:0] write_recovery_code;
  logic [5:0] total_read_latency, total_write_latency;
  int num_errors = 0;
  int checked = 0;

  ctrl_model u_ctrl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));

  ddr3_mode_register_decode u_dut (.clk(clk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rd_col(rd_col), .rd_beat_valid(rd_beat_valid), .dq_oe(dq_oe), .dqs_oe(dqs_oe),
    .int_read(int_read), .wr_col(wr_col), .wr_beat_valid(wr_beat_valid),
    .int_write(int_write), .write_commit(write_commit), .dll_running(dll_running),
    .dll_locked(dll_locked), .dll_reset_busy(dll_reset_busy),
    .drive_impedance(drive_impedance), .test_mode(test_mode),
    .write_recovery_code(write_recovery_code), .total_read_latency(total_read_latency),
    .total_write_latency(total_write_latency));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  function automatic logic pick(input int w);
    case (w)
      0: return rd_beat_valid;
      1: return wr_beat_valid;
      2: return int_read;
      3: return int_write;
      default: return dll_locked;
    endcase
  endfunction : pick

  // Counts cycles since the command cycle until the chosen output rises
  task automatic meas(input int w, inout int n);
    do begin
      @(negedge clk);
      n++;
    end while (pick(w) !== 1'b1 && n < 300);
  endtask : meas

  function automatic logic [2:0] exp_col(logic [2:0] s, logic [2:0] b, logic il, logic ch,
    logic w);
    if (w) return ch ? {s[2], b[1:0]} : b;
    if (il) return s ^ b;
    return {s[2] ^ b[2], s[1:0] + b[1:0]};
  endfunction : exp_col

  task automatic burst(input logic w, input logic [2:0] s, input logic [1:0] bl,
    input logic bc, input logic il);
    int n;
    int c;
    logic ch;
    logic v;
    logic [2:0] col;
    ch = (bl == BL_FIXED_FOUR) || (bl == BL_ON_THE_FLY && !bc);
    n = 0;
    c = 0;
    u_ctrl.issue(w ? CMD_WRITE : CMD_READ, 3'h0, {1'b0, bc, 9'h000, s});
    meas(w ? 1 : 0, n);
    chk(32'(n), w ? 32'h5 : 32'h4);
    for (int b = 0; b < 8; b++) begin
      if (b > 0) @(negedge clk);
      if (write_commit === 1'b1) c = n + b;
      v = w ? wr_beat_valid : rd_beat_valid;
      col = w ? wr_col : rd_col;
      if (ch && b > 3) begin
        chk({30'h0, v, !w && (dq_oe || dqs_oe)}, 32'h0);
      end else begin
        chk({28'h0, v, col}, {28'h1, exp_col(s, b[2:0], il, ch, w)});
        if (!w) chk({30'h0, dq_oe, dqs_oe}, 32'h3);
      end
    end
    if (w) chk(32'(c), bl == BL_FIXED_FOUR ? 32'h7 : 32'h9);
  endtask : burst

  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] bl;
    int n;
    int rd_set;
    int add_lat;
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    u_ctrl.cke_set(1'b1, 1'b0);
    rd(REG_LOCK_LIMIT, d);
    chk(d, 32'(LOOP_LOCK_CK));
    rd(REG_STATUS, d);
    chk(d & 32'hfff, 32'h144);
    rd(3'h7, d);
    chk(d, 32'h0);
    wr(REG_MODE_ZERO, 32'h1fff);
    rd(REG_MODE_ZERO, d);
    chk(d, 32'h0);
    for (int w = 0; w < 2; w++) begin
      for (int il = 0; il < 2; il++) begin
        for (int k = 0; k < 4; k++) begin
          bl = (k == 0) ? BL_FIXED_EIGHT : (k < 3) ? BL_ON_THE_FLY : BL_FIXED_FOUR;
          u_ctrl.mrs(BA_MODE_ZERO, {10'h000, il[0], 1'b0, bl});
          repeat (2) @(posedge clk);
          for (int s = 0; s < 8; s++) burst(w[0], s[2:0], bl, k == 1, il[0]);
        end
      end
    end
    for (int i = 0; i < 6; i++) begin
      rd_set = i + 4 + (i % 2) * 8;
      add_lat = (i % 4 == 1) ? rd_set - 1 : (i % 4 == 2) ? rd_set - 2 : 0;
      u_ctrl.mrs(BA_MODE_ZERO, {7'h00, 3'(i), 1'b0, i[0], 2'h0});
      u_ctrl.mrs(BA_MODE_ONE, {9'h000, 2'(i % 4), 3'h0});
      u_ctrl.mrs(BA_MODE_TWO, {8'h00, 3'(i), 3'h0});
      repeat (3) @(negedge clk);
      chk(32'(total_read_latency), 32'(add_lat + rd_set));
      chk(32'(total_write_latency), 32'(add_lat + i + 5));
      n = 0;
      u_ctrl.issue(CMD_READ, 3'h0, 14'h0000);
      meas(2, n);
      chk(32'(n), 32'(add_lat + 1));
      meas(0, n);
      chk(32'(n), 32'(add_lat + rd_set));
      repeat (8) @(posedge clk);
      n = 0;
      u_ctrl.issue(CMD_WRITE, 3'h0, 14'h0000);
      meas(3, n);
      chk(32'(n), 32'(add_lat + 1));
      meas(1, n);
      chk(32'(n), 32'(add_lat + i + 5));
      repeat (10) @(posedge clk);
    end
    rd(REG_MODE_TWO, d);
    chk(d, 32'h28);
    u_ctrl.mrs(BA_MODE_ONE, 14'h0000);
    for (int i = 0; i < 8; i++) begin
      u_ctrl.mrs(BA_MODE_ONE, {8'h00, i[1], 3'h0, i[0], 1'b0});
      u_ctrl.mrs(BA_MODE_ZERO, {2'h0, 3'(i), 1'b0, 1'b1, 7'h00});
      repeat (3) @(negedge clk);
      chk(32'(drive_impedance), 32'(i % 4));
      chk({27'h0, test_mode, write_recovery_code}, {27'h0, 1'b1, 1'b0, 3'(i)});
      rd(REG_MODE_ZERO, d);
      chk(d, {20'h0, 3'(i), 9'h080});
    end
    u_ctrl.mrs(3'h3, 14'h0000);
    rd(REG_MODE_ZERO, d);
    chk(d, 32'h0e80);
    rd(REG_MODE_ONE, d);
    chk(d, 32'h0022);
    wr(REG_LOCK_LIMIT, 32'h8);
    u_ctrl.mrs(BA_MODE_ZERO, 14'h0100);
    @(negedge clk);
    chk({30'h0, dll_reset_busy, dll_locked}, 32'h2);
    n = 1;
    meas(4, n);
    chk(32'(n > 9 && n < 14), 32'h1);
    rd(REG_MODE_ZERO, d);
    chk(d, 32'h0);
    for (int j = 0; j < 3; j++) begin
      u_ctrl.mrs(BA_MODE_ZERO, j == 1 ? 14'h1000 : 14'h0000);
      repeat (2) @(posedge clk);
      u_ctrl.cke_set(1'b0, j == 2);
      repeat (3) @(negedge clk);
      chk(32'(dll_running), 32'(j == 1));
      if (j == 0) u_ctrl.mrs(BA_MODE_ZERO, 14'h0e00);
      u_ctrl.cke_set(1'b1, 1'b0);
      repeat (3) @(negedge clk);
      chk({27'h0, dll_running, write_recovery_code}, 32'h10);
    end
    u_ctrl.mrs(BA_MODE_ONE, 14'h0001);
    repeat (3) @(negedge clk);
    chk(32'(dll_running), 32'h0);
    u_ctrl.mrs(BA_MODE_ONE, 14'h0000);
    repeat (3) @(negedge clk);
    chk(32'(dll_running), 32'h1);
    close_out();
  end
endmodule : ddr3_mode_register_decode_tb
`default_nettype wire
